// *** design/ncs_sequencer.sv ***
// Purpose: Command port, one-entry waiting stage and bank status log
// Assumes: bankBusy rises the cycle after cmdValid for that bank
// Notes: Bus reads answer one cycle after the read strobe
`timescale 1ns/1ps

// Overview of operation
// R1: Software loads the port, device moves it through stage to bank and log
// R2: Issue action copies the whole loaded descriptor into the waiting stage
// R3: Stage contents go to the bank named in the descriptor
// R4: Busy target bank keeps the descriptor waiting until it goes idle
// R5: Every forwarded command is logged in that bank's status entry
// R6: Bank interrupt causes are recorded in that bank's cause register
// R7: Codes 00,01,02,03,04,09 decode as wait and program-type operations
// R8: Codes 0a,0b,0c,0f,10,12,16,17 decode as read, id and copy operations
// R9: Software writes bank numbers within the bank count
// R10: Bank field 3f selects automatic bank choice
// R11: Automatic choice gives the stage to the first idle bank
// R12: Option 001 enables two-plane, option 006 enables ECC and CRC
// R13: Option 008 enables the scrambler
// R14: Option 010 disables the low chip of the pair
// R15: Option 020 disables the high chip of the pair
// R16: Option 040 waits for write data ready, 080 ties to host write buffer
// R17: Option 100 releases the host read buffer once the command completes
// R18: Buffer address is passed on as DRAM location, software keeps alignment
// R19: Software writes transfer lengths in multiples of 512 bytes
// R20: Any write to the issue register hands over the loaded descriptor; the code drops one made while the stage is full
// R21: Status bit 0 reads zero when stage empty; issue only when empty
// R22: ECC with a disabled chip raises the data corruption cause
// R23: Port registers keep their values after issue until rewritten
module ncs_sequencer
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] busAddr,
	input wire logic [31:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [31:0] busRdata,
	input wire logic [ncs_pkg::NUM_BANKS-1:0] bankBusy,
	input wire logic writeDataReady,
	input wire logic irqValid,
	input wire logic [4:0] irqBank,
	input wire logic [7:0] irqCause,
	output logic cmdValid,
	output logic [4:0] cmdBank,
	output logic [7:0] cmdOpcode,
	output logic [8:0] cmdOption,
	output logic [31:0] cmdBufAddr,
	output logic [31:0] cmdLength,
	output logic cmdToFlash,
	output logic cmdTwoPlane,
	output logic cmdEcc,
	output logic cmdScramble,
	output logic cmdHostWrite,
	output logic lowChipEnable,
	output logic highChipEnable,
	output logic readRelease,
	output logic [4:0] readReleaseBank
);
	import ncs_pkg::*;

	// ==========================================================
	// Helper functions

	// Lowest idle bank, or the automatic code when every bank is busy
	function automatic logic [5:0] firstIdle(logic [NUM_BANKS-1:0] busy);
		logic [5:0] pick;
		pick = BANK_AUTO;
		for (int i = NUM_BANKS - 1; i >= 0; i--)
		begin
			if (!busy[i])
				pick = 6'(i);
		end
		return pick;
	endfunction

	// Lowest set bit index of a request vector
	function automatic logic [4:0] lowestSet(logic [NUM_BANKS-1:0] v);
		logic [4:0] pick;
		pick = 5'h00;
		for (int i = NUM_BANKS - 1; i >= 0; i--)
		begin
			if (v[i])
				pick = 5'(i);
		end
		return pick;
	endfunction

	// Operations that move data toward the flash array
	function automatic logic opWritesFlash(logic [7:0] code);
		logic r;
		r = 1'b0;
		case (code)
			OP_ADDR_INPUT_PROGRAM, OP_ADDR_INPUT, OP_INPUT,
			OP_INPUT_PROGRAM, OP_PROGRAM, OP_COPY_BACK,
			OP_MODIFIED_COPY_BACK: r = 1'b1; // see R7
			OP_WAIT, OP_ADDR_READ_OUTPUT, OP_ADDR_READ, OP_OUTPUT,
			OP_COLUMN_OUTPUT, OP_READ_IDENTIFIER,
			OP_GENERIC_ADDRESS: r = 1'b0; // see R8
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Command port registers
	logic [31:0] opBankReg;
	logic [8:0] optionReg;
	logic [31:0] bufAddrReg;
	logic [31:0] lengthReg;
	logic issueWrite;

	assign issueWrite = busWrite && busAddr == ADDR_ISSUE; // see R20

	// Held until software rewrites them, so issue can be repeated
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			opBankReg <= OP_BANK_RESET;
			optionReg <= OPTION_RESET;
			bufAddrReg <= WORD_RESET;
			lengthReg <= WORD_RESET;
		end
		else if (busWrite)
		begin
			if (busAddr == ADDR_OP_BANK)
				opBankReg <= busWdata; // see R23
			if (busAddr == ADDR_OPTION)
				optionReg <= busWdata[8:0];
			if (busAddr == ADDR_BUF_ADDR)
				bufAddrReg <= busWdata; // see R18
			if (busAddr == ADDR_LENGTH)
				lengthReg <= busWdata;
		end
	end

	// ==========================================================
	// Waiting stage
	logic stageFullReg;
	logic [7:0] stageOpReg;
	logic [5:0] stageBankReg;
	logic [8:0] stageOptReg;
	logic [31:0] stageAddrReg;
	logic [31:0] stageLenReg;
	logic [5:0] idlePick;
	logic [5:0] target;
	logic targetFree;
	logic dataGate;
	logic dispatch;

	assign idlePick = firstIdle(bankBusy);
	// Automatic mode takes the lowest idle bank this cycle
	assign target = (stageBankReg == BANK_AUTO) ? idlePick
		: stageBankReg; // see R10
	assign targetFree = target < 6'(NUM_BANKS)
		&& !bankBusy[target[4:0]]; // see R4
	assign dataGate = !(|(stageOptReg & OPT_WR_READY_WAIT))
		|| writeDataReady; // see R16
	assign dispatch = stageFullReg && targetFree && dataGate; // see R3

	// A second issue while full is dropped: it cannot be tracked
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			stageFullReg <= 1'b0;
		else if (issueWrite && !stageFullReg)
			stageFullReg <= 1'b1; // see R21
		else if (dispatch)
			stageFullReg <= 1'b0;
	end

	// Snapshot of the whole descriptor on issue
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stageOpReg <= 8'h00;
			stageBankReg <= 6'h00;
			stageOptReg <= OPTION_RESET;
			stageAddrReg <= WORD_RESET;
			stageLenReg <= WORD_RESET;
		end
		else if (issueWrite && !stageFullReg)
		begin
			stageOpReg <= opBankReg[OP_LSB+:8]; // see R2
			stageBankReg <= opBankReg[BANK_LSB+:6];
			stageOptReg <= optionReg;
			stageAddrReg <= bufAddrReg;
			stageLenReg <= lengthReg;
		end
	end

	// ==========================================================
	// Command outputs toward the banks
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cmdValid <= 1'b0;
			cmdBank <= 5'h00;
			cmdOpcode <= 8'h00;
			cmdOption <= OPTION_RESET;
			cmdBufAddr <= WORD_RESET;
			cmdLength <= WORD_RESET;
			cmdToFlash <= 1'b0;
			cmdTwoPlane <= 1'b0;
			cmdEcc <= 1'b0;
			cmdScramble <= 1'b0;
			cmdHostWrite <= 1'b0;
			lowChipEnable <= 1'b1;
			highChipEnable <= 1'b1;
		end
		else
		begin
			cmdValid <= dispatch; // see R1
			if (dispatch)
			begin
				cmdBank <= target[4:0]; // see R11
				cmdOpcode <= stageOpReg;
				cmdOption <= stageOptReg;
				cmdBufAddr <= stageAddrReg;
				cmdLength <= stageLenReg;
				cmdToFlash <= opWritesFlash(stageOpReg);
				cmdTwoPlane <= |(stageOptReg & OPT_TWO_PLANE); // see R12
				cmdEcc <= (stageOptReg & OPT_ECC) == OPT_ECC; // see R12
				cmdScramble <= |(stageOptReg & OPT_SCRAMBLE); // see R13
				cmdHostWrite <= |(stageOptReg & OPT_HOST_WRITE); // see R16
				lowChipEnable <= !(|(stageOptReg & OPT_LOW_OFF)); // see R14
				highChipEnable <= !(|(stageOptReg & OPT_HIGH_OFF)); // see R15
			end
		end
	end

	// ==========================================================
	// Last automatically chosen bank
	logic [5:0] autoBankReg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			autoBankReg <= 6'h00;
		else if (dispatch && stageBankReg == BANK_AUTO)
			autoBankReg <= target; // see R11
	end

	// ==========================================================
	// Bank status log, four descriptor words per bank
	logic [31:0] logOpBank [NUM_BANKS];
	logic [31:0] logOpt [NUM_BANKS];
	logic [31:0] logAddr [NUM_BANKS];
	logic [31:0] logLen [NUM_BANKS];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_BANKS; i++)
			begin
				logOpBank[i] <= WORD_RESET;
				logOpt[i] <= WORD_RESET;
				logAddr[i] <= WORD_RESET;
				logLen[i] <= WORD_RESET;
			end
		end
		else if (dispatch)
		begin
			logOpBank[target[4:0]] <= {18'h00000, stageBankReg,
				stageOpReg}; // see R5
			logOpt[target[4:0]] <= {23'h000000, stageOptReg};
			logAddr[target[4:0]] <= stageAddrReg;
			logLen[target[4:0]] <= stageLenReg;
		end
	end

	// ==========================================================
	// Interrupt causes, one byte per bank, write one to clear
	logic [7:0] causeReg [NUM_BANKS];
	logic causeHit;
	logic [2:0] causeWord;
	logic corruptSet;

	assign causeHit = busWrite && busAddr >= ADDR_CAUSE_BASE
		&& busAddr < ADDR_CAUSE_END;
	assign causeWord = 3'((busAddr - ADDR_CAUSE_BASE) >> 2);
	// ECC checking cannot cover a disabled chip
	assign corruptSet = (stageOptReg & OPT_ECC) == OPT_ECC
		&& |(stageOptReg & (OPT_LOW_OFF | OPT_HIGH_OFF)); // see R22

	// Sets are applied after clears so a same-cycle event survives
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_BANKS; i++)
				causeReg[i] <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < NUM_BANKS; i++)
				causeReg[i] <= (causeReg[i]
					& ~((causeHit && causeWord == 3'(i / 4))
					? busWdata[(i % 4) * 8+:8] : 8'h00))
					| ((irqValid && irqBank == 5'(i))
					? irqCause : 8'h00) // see R6
					| ((dispatch && corruptSet && target == 6'(i))
					? CAUSE_DATA_CORRUPT : 8'h00); // see R22
		end
	end

	// ==========================================================
	// Host read buffer release after completion
	logic [NUM_BANKS-1:0] releasePendReg;
	logic [NUM_BANKS-1:0] releaseDue;
	logic [4:0] releasePick;

	assign releaseDue = releasePendReg & ~bankBusy;
	assign releasePick = lowestSet(releaseDue);

	// Pending is armed on cmdValid, the cycle after dispatch; busy is expected from that same edge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			releasePendReg <= '0;
			readRelease <= 1'b0;
			readReleaseBank <= 5'h00;
		end
		else
		begin
			readRelease <= |releaseDue && !cmdValid; // see R17
			if (|releaseDue && !cmdValid)
			begin
				readReleaseBank <= releasePick;
				releasePendReg[releasePick] <= 1'b0;
			end
			if (cmdValid && |(cmdOption & OPT_READ_RELEASE))
				releasePendReg[cmdBank] <= 1'b1;
		end
	end

	// ==========================================================
	// Register read path
	logic [31:0] readNext;
	logic [31:0] logOff;
	logic [31:0] logBank;
	logic [31:0] logWord;

	assign logOff = busAddr - ADDR_LOG_BASE;
	assign logBank = logOff / LOG_STRIDE;
	assign logWord = (logOff % LOG_STRIDE) >> 2;

	// Unmapped addresses read as zero
	always_comb
	begin
		readNext = 32'h0000_0000;
		if (busAddr == ADDR_STAGE_STATUS)
			readNext = {31'h00000000, stageFullReg}; // see R21
		else if (busAddr == ADDR_AUTO_BANK)
			readNext = {26'h0000000, autoBankReg};
		else if (busAddr == ADDR_OP_BANK)
			readNext = opBankReg;
		else if (busAddr == ADDR_OPTION)
			readNext = {23'h000000, optionReg};
		else if (busAddr == ADDR_BUF_ADDR)
			readNext = bufAddrReg;
		else if (busAddr == ADDR_LENGTH)
			readNext = lengthReg;
		else if (busAddr >= ADDR_CAUSE_BASE && busAddr < ADDR_CAUSE_END)
			readNext = {causeReg[causeWord * 4 + 3],
				causeReg[causeWord * 4 + 2],
				causeReg[causeWord * 4 + 1], causeReg[causeWord * 4]};
		else if (busAddr >= ADDR_LOG_BASE && logBank < NUM_BANKS
			&& logWord < LOG_WORDS)
		begin
			unique case (logWord[1:0])
				2'd0: readNext = logWord < 4 ? logOpBank[logBank[4:0]] : '0;
				2'd1: readNext = logWord < 4 ? logOpt[logBank[4:0]] : '0;
				2'd2: readNext = logWord < 4 ? logAddr[logBank[4:0]] : '0;
				2'd3: readNext = logWord < 4 ? logLen[logBank[4:0]] : '0;
			endcase
		end
	end

	// Data only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			busRdata <= 32'h0000_0000;
		else
			busRdata <= busRead ? readNext : 32'h0000_0000;
	end

	// ==========================================================
	// Assertions
	sequence s_issueEmpty;
		issueWrite && !stageFullReg;
	endsequence

	sequence s_loaded;
		stageFullReg && stageOpReg == $past(opBankReg[7:0]);
	endsequence

	property p_issueLoads;
		@(posedge clk) disable iff (!rst_n)
		s_issueEmpty |=> s_loaded;
	endproperty
	a_issueLoads: assert property (p_issueLoads) // see R2
		else $error("Issue did not load the waiting stage");

	property p_busyHolds;
		@(posedge clk) disable iff (!rst_n)
		stageFullReg && stageBankReg != BANK_AUTO
			&& stageBankReg < 6'(NUM_BANKS)
			&& bankBusy[stageBankReg[4:0]] |=> !cmdValid && stageFullReg;
	endproperty
	a_busyHolds: assert property (p_busyHolds) // see R4
		else $error("Command left stage toward a busy bank");

	property p_rightBank;
		@(posedge clk) disable iff (!rst_n)
		dispatch && stageBankReg != BANK_AUTO
			|=> cmdValid && cmdBank == $past(stageBankReg[4:0]);
	endproperty
	a_rightBank: assert property (p_rightBank) // see R3
		else $error("Command sent to the wrong bank");

	property p_logged;
		@(posedge clk) disable iff (!rst_n)
		cmdValid |-> logAddr[cmdBank] == cmdBufAddr
			&& logLen[cmdBank] == cmdLength;
	endproperty
	a_logged: assert property (p_logged) // see R5
		else $error("Forwarded command missing from status log");

	property p_autoIdle;
		@(posedge clk) disable iff (!rst_n)
		dispatch && stageBankReg == BANK_AUTO
			|-> !bankBusy[idlePick[4:0]]
			&& (bankBusy & ((32'h1 << idlePick[4:0]) - 32'h1))
			== ((32'h1 << idlePick[4:0]) - 32'h1)
			##1 cmdValid && autoBankReg == {1'b0, cmdBank};
	endproperty
	a_autoIdle: assert property (p_autoIdle) // see R11
		else $error("Automatic choice picked a busy bank");

	property p_chipEnables;
		@(posedge clk) disable iff (!rst_n)
		cmdValid |-> lowChipEnable == !cmdOption[4]
			&& highChipEnable == !cmdOption[5] && cmdScramble == cmdOption[3];
	endproperty
	a_chipEnables: assert property (p_chipEnables) // see R14
		else $error("Chip enables disagree with option flags");

	property p_irqRecorded;
		@(posedge clk) disable iff (!rst_n)
		irqValid |=> (causeReg[$past(irqBank)] & $past(irqCause))
			== $past(irqCause);
	endproperty
	a_irqRecorded: assert property (p_irqRecorded) // see R6
		else $error("Bank interrupt cause was lost");

	property p_corrupt;
		@(posedge clk) disable iff (!rst_n)
		cmdValid && cmdEcc && !(lowChipEnable && highChipEnable)
			|-> (causeReg[cmdBank] & CAUSE_DATA_CORRUPT) == CAUSE_DATA_CORRUPT;
	endproperty
	a_corrupt: assert property (p_corrupt) // see R22
		else $error("Data corruption cause not raised");

	property p_retain;
		@(posedge clk) disable iff (!rst_n)
		issueWrite |=> $stable(opBankReg) && $stable(optionReg);
	endproperty
	a_retain: assert property (p_retain) // see R23
		else $error("Port registers changed on issue");

	property p_status;
		@(posedge clk) disable iff (!rst_n)
		busRead && busAddr == ADDR_STAGE_STATUS
			|=> busRdata[0] == $past(stageFullReg);
	endproperty
	a_status: assert property (p_status) // see R21
		else $error("Stage status bit reads wrong");
endmodule

// *** design/ncs_pkg.sv ***
// Purpose: Constants and types shared by the command port sequencer
// Assumes: 32-bit register bus with byte addresses
// Notes: Field positions inside the command word are fixed here
package ncs_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_BANKS = 32;
	localparam int LOG_WORDS = 12;
	localparam logic [31:0] LOG_STRIDE = 32'h0000_0030;
	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] ADDR_STAGE_STATUS = 32'h6000_002c;
	localparam logic [31:0] ADDR_AUTO_BANK = 32'h6000_0030;
	localparam logic [31:0] ADDR_OP_BANK = 32'h6000_0034;
	localparam logic [31:0] ADDR_OPTION = 32'h6000_003c;
	localparam logic [31:0] ADDR_BUF_ADDR = 32'h6000_0040;
	localparam logic [31:0] ADDR_LENGTH = 32'h6000_0044;
	localparam logic [31:0] ADDR_ISSUE = 32'h6000_015c;
	localparam logic [31:0] ADDR_LOG_BASE = 32'h6000_0160;
	localparam logic [31:0] ADDR_CAUSE_BASE = 32'h6000_0760;
	localparam logic [31:0] ADDR_CAUSE_END = 32'h6000_0780;
	// ==========================================================
	// Field positions and reset values
	localparam int OP_LSB = 0;
	localparam int BANK_LSB = 8;
	localparam logic [31:0] OP_BANK_RESET = 32'h0000_0000;
	localparam logic [8:0] OPTION_RESET = 9'h000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [5:0] BANK_AUTO = 6'h3f;
	// ==========================================================
	// Option flag values
	localparam logic [8:0] OPT_TWO_PLANE = 9'h001;
	localparam logic [8:0] OPT_ECC = 9'h006;
	localparam logic [8:0] OPT_SCRAMBLE = 9'h008;
	localparam logic [8:0] OPT_LOW_OFF = 9'h010;
	localparam logic [8:0] OPT_HIGH_OFF = 9'h020;
	localparam logic [8:0] OPT_WR_READY_WAIT = 9'h040;
	localparam logic [8:0] OPT_HOST_WRITE = 9'h080;
	localparam logic [8:0] OPT_READ_RELEASE = 9'h100;
	// ==========================================================
	// Interrupt cause written for ECC with a chip disabled
	localparam logic [7:0] CAUSE_DATA_CORRUPT = 8'h82;
	// ==========================================================
	// Operation codes
	typedef enum logic [7:0] {
		OP_WAIT = 8'h00, OP_ADDR_INPUT_PROGRAM = 8'h01,
		OP_ADDR_INPUT = 8'h02, OP_INPUT = 8'h03,
		OP_INPUT_PROGRAM = 8'h04, OP_PROGRAM = 8'h09,
		OP_ADDR_READ_OUTPUT = 8'h0a, OP_ADDR_READ = 8'h0b,
		OP_OUTPUT = 8'h0c, OP_COLUMN_OUTPUT = 8'h0f,
		OP_READ_IDENTIFIER = 8'h10, OP_COPY_BACK = 8'h12,
		OP_GENERIC_ADDRESS = 8'h16, OP_MODIFIED_COPY_BACK = 8'h17
	} ncs_op_type;
endpackage

// *** verification/ncs_bank_model.sv ***
// Purpose: Behavioural model of the flash banks behind the sequencer
// Assumes: One busy counter per bank, loaded when a command arrives
// Notes: holdBusy lets the bench keep any bank busy for as long as it likes
`timescale 1ns/1ps
module ncs_bank_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire logic [4:0] cmdBank,
	input wire logic [7:0] busyLen,
	input wire logic [ncs_pkg::NUM_BANKS-1:0] holdBusy,
	output logic [ncs_pkg::NUM_BANKS-1:0] bankBusy
);
	import ncs_pkg::*;
	// ==========================================================
	// Operation timers
	logic [7:0] busyLeft_reg [NUM_BANKS];
	// Busy rises the edge after the command, as the sequencer expects
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			if (!rst_n)
				busyLeft_reg[i] <= 8'h00;
			else if (cmdValid && cmdBank == i[4:0])
				busyLeft_reg[i] <= busyLen;
			else if (busyLeft_reg[i] != 8'h00)
				busyLeft_reg[i] <= busyLeft_reg[i] - 8'h01;
		end
	end
	// A bank stays busy until its operation ends; no early idle
	always_comb
	begin
		for (int i = 0; i < NUM_BANKS; i++)
			bankBusy[i] = holdBusy[i] | (busyLeft_reg[i] != 8'h00);
	end
endmodule

// *** verification/tb_nand_command_port_sequencer.sv ***
// Purpose: Self-checking bench for the command port sequencer
// Assumes: Bank model raises busy the edge after each forwarded command
// Notes: Bus tasks take two cycles so no strobe toggles twice at one edge
`timescale 1ns/1ps
module tb_nand_command_port_sequencer;
	import ncs_pkg::*;
	// ==========================================================
	// Signals
	logic clk, rst_n, busWrite, busRead, writeDataReady, irqValid;
	logic [31:0] busAddr, busWdata, busRdata, cmdBufAddr, cmdLength, d;
	logic [NUM_BANKS-1:0] bankBusy, holdBusy;
	logic [4:0] irqBank, cmdBank, readReleaseBank;
	logic [7:0] irqCause, cmdOpcode, busyLen;
	logic [8:0] cmdOption;
	logic cmdValid, cmdToFlash, cmdTwoPlane, cmdEcc, cmdScramble;
	logic cmdHostWrite, lowChipEnable, highChipEnable, readRelease;
	int nMismatch, totalChecks, nCmd, cyc, n0;
	logic [7:0] ops [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h09,
		8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h10, 8'h12, 8'h16, 8'h17};
	logic [8:0] opts [8] = '{9'h000, OPT_TWO_PLANE, 9'h002, OPT_ECC,
		OPT_SCRAMBLE, OPT_LOW_OFF, OPT_HIGH_OFF, OPT_HOST_WRITE};
	logic [31:0] rstRegs [7] = '{ADDR_STAGE_STATUS, ADDR_OP_BANK,
		ADDR_OPTION, ADDR_BUF_ADDR, ADDR_LENGTH, ADDR_CAUSE_BASE,
		32'h6000_0038};
	// ==========================================================
	// Design and bank model
	ncs_sequencer dut_u (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
		.busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
		.busRdata(busRdata), .bankBusy(bankBusy),
		.writeDataReady(writeDataReady), .irqValid(irqValid),
		.irqBank(irqBank), .irqCause(irqCause), .cmdValid(cmdValid),
		.cmdBank(cmdBank), .cmdOpcode(cmdOpcode), .cmdOption(cmdOption),
		.cmdBufAddr(cmdBufAddr), .cmdLength(cmdLength),
		.cmdToFlash(cmdToFlash), .cmdTwoPlane(cmdTwoPlane), .cmdEcc(cmdEcc),
		.cmdScramble(cmdScramble), .cmdHostWrite(cmdHostWrite),
		.lowChipEnable(lowChipEnable), .highChipEnable(highChipEnable),
		.readRelease(readRelease), .readReleaseBank(readReleaseBank));
	ncs_bank_model bank_u (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
		.cmdBank(cmdBank), .busyLen(busyLen), .holdBusy(holdBusy),
		.bankBusy(bankBusy));
	// Clock at 100 MHz
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count forwarded commands so stalls can be proven
	always @(posedge clk)
		if (cmdValid === 1'b1)
			nCmd <= nCmd + 1;
	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Strobe lowered one edge before return, so calls may follow directly
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		busAddr <= a;
		busWdata <= v;
		busWrite <= 1'b1;
		@(posedge clk);
		busWrite <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		busAddr <= a;
		busRead <= 1'b1;
		@(posedge clk);
		busRead <= 1'b0;
		#1;
		v = busRdata;
		@(posedge clk);
	endtask
	function automatic logic flashOp(input logic [7:0] op);
		return op inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h12, 8'h17};
	endfunction
	task automatic issue(input logic [5:0] b, input logic [7:0] op,
		input logic [8:0] opt, input logic [31:0] a);
		wr(ADDR_OP_BANK, {18'h0, b, op});
		wr(ADDR_OPTION, {23'h0, opt});
		wr(ADDR_BUF_ADDR, a);
		wr(ADDR_LENGTH, 32'h0000_0400);
		wr(ADDR_ISSUE, 32'h0000_0000);
	endtask
	task automatic waitCmd(input logic [4:0] b, input logic [7:0] op,
		input logic [8:0] opt, input logic [31:0] a);
		cyc = 0;
		#1;
		while (cmdValid !== 1'b1 && cyc < 60)
		begin
			@(posedge clk);
			#1;
			cyc++;
		end
		chk("cmdValid", cmdValid, 32'h1);
		chk("cmdBank", cmdBank, b);
		chk("cmdOpcode", cmdOpcode, op);
		chk("cmdOption", cmdOption, opt);
		chk("cmdBufAddr", cmdBufAddr, a);
		chk("cmdLength", cmdLength, 32'h0000_0400);
		chk("cmdToFlash", cmdToFlash, flashOp(op));
		chk("cmdTwoPlane", cmdTwoPlane, (opt & OPT_TWO_PLANE) != 0);
		chk("cmdEcc", cmdEcc, (opt & OPT_ECC) == OPT_ECC);
		chk("cmdScramble", cmdScramble, (opt & OPT_SCRAMBLE) != 0);
		chk("lowChipEnable", lowChipEnable, (opt & OPT_LOW_OFF) == 0);
		chk("highChipEnable", highChipEnable, (opt & OPT_HIGH_OFF) == 0);
		chk("cmdHostWrite", cmdHostWrite, (opt & OPT_HOST_WRITE) != 0);
		@(posedge clk);
	endtask
	task automatic end_sim();
		if (nMismatch == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Watchdog, well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		end_sim();
	end
	// ==========================================================
	// Test sequence
	initial
	begin
		rst_n = 1'b0;
		busAddr = 32'h0;
		busWdata = 32'h0;
		busWrite = 1'b0;
		busRead = 1'b0;
		writeDataReady = 1'b1;
		irqValid = 1'b0;
		irqBank = 5'h00;
		irqCause = 8'h00;
		holdBusy = '0;
		busyLen = 8'h04;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("lowChipEnable", lowChipEnable, 32'h1);
		chk("highChipEnable", highChipEnable, 32'h1);
		foreach (rstRegs[i])
		begin
			rd(rstRegs[i], d);
			chk("resetRead", d, 32'h0);
		end
		// Every code, with the option values spread over the banks
		foreach (ops[i])
		begin
			issue(i[5:0], ops[i], opts[i % 8], 32'h200 * i);
			waitCmd(i[4:0], ops[i], opts[i % 8], 32'h200 * i);
		end
		rd(ADDR_OP_BANK, d);
		chk("opBankKept", d, 32'h0000_0d17);
		rd(ADDR_LOG_BASE + LOG_STRIDE * 13, d);
		chk("logWord0", d, 32'h0000_0d17);
		rd(ADDR_LOG_BASE + LOG_STRIDE * 13 + 4, d);
		chk("logWord1", d, 32'h0000_0010);
		rd(ADDR_LOG_BASE + LOG_STRIDE * 13 + 8, d);
		chk("logWord2", d, 32'h0000_1a00);
		rd(ADDR_LOG_BASE + LOG_STRIDE * 13 + 12, d);
		chk("logWord3", d, 32'h0000_0400);
		// ECC with one chip off marks both banks as corrupt
		issue(6'd6, 8'h0b, OPT_ECC | OPT_HIGH_OFF, 32'h2000);
		waitCmd(5'd6, 8'h0b, OPT_ECC | OPT_HIGH_OFF, 32'h2000);
		issue(6'd7, 8'h0b, OPT_ECC | OPT_LOW_OFF, 32'h2200);
		waitCmd(5'd7, 8'h0b, OPT_ECC | OPT_LOW_OFF, 32'h2200);
		rd(ADDR_CAUSE_BASE + 4, d);
		chk("causeCorrupt", d, 32'h8282_0000);
		wr(ADDR_CAUSE_BASE + 4, 32'hffff_0000);
		rd(ADDR_CAUSE_BASE + 4, d);
		chk("causeCleared", d, 32'h0);
		// Bank event lands in its own byte
		irqValid <= 1'b1;
		irqBank <= 5'd9;
		irqCause <= 8'h04;
		@(posedge clk);
		irqValid <= 1'b0;
		@(posedge clk);
		rd(ADDR_CAUSE_BASE + 8, d);
		chk("causeIrq", d, 32'h0000_0400);
		// Busy target: stage holds, a second issue is dropped
		holdBusy <= 32'h0000_0004;
		n0 = nCmd;
		issue(6'd2, 8'h0b, 9'h000, 32'h4000);
		repeat (20) @(posedge clk);
		chk("heldWhileBusy", nCmd - n0, 32'h0);
		rd(ADDR_STAGE_STATUS, d);
		chk("stageFull", d & 32'h1, 32'h1);
		wr(ADDR_OP_BANK, 32'h0000_030c);
		wr(ADDR_ISSUE, 32'h0000_0000);
		holdBusy <= '0;
		waitCmd(5'd2, 8'h0b, 9'h000, 32'h4000);
		repeat (20) @(posedge clk);
		chk("dropped", nCmd - n0, 32'h1);
		rd(ADDR_STAGE_STATUS, d);
		chk("stageEmpty", d & 32'h1, 32'h0);
		// Automatic choice skips busy banks 0..2
		holdBusy <= 32'h0000_0007;
		issue(BANK_AUTO, 8'h02, 9'h000, 32'h6000);
		waitCmd(5'd3, 8'h02, 9'h000, 32'h6000);
		holdBusy <= '0;
		rd(ADDR_AUTO_BANK, d);
		chk("autoBank", d, 32'h3);
		// Write-ready gate holds the command until data is ready
		writeDataReady <= 1'b0;
		n0 = nCmd;
		issue(6'd11, 8'h03, OPT_WR_READY_WAIT, 32'h8000);
		repeat (15) @(posedge clk);
		chk("gatedWait", nCmd - n0, 32'h0);
		writeDataReady <= 1'b1;
		waitCmd(5'd11, 8'h03, OPT_WR_READY_WAIT, 32'h8000);
		// Read buffer released only after the bank goes idle
		issue(6'd12, 8'h0a, OPT_READ_RELEASE, 32'ha000);
		waitCmd(5'd12, 8'h0a, OPT_READ_RELEASE, 32'ha000);
		cyc = 0;
		while (readRelease !== 1'b1 && cyc < 40)
		begin
			@(posedge clk);
			#1;
			cyc++;
		end
		chk("releaseTime", cyc >= 4 && cyc < 40, 32'h1);
		chk("releaseBank", readReleaseBank, 32'd12);
		@(posedge clk);
		end_sim();
	end
endmodule
